// file: verilog/rtc_defines.vh
`ifndef RTC_DEFINES_VH
`define RTC_DEFINES_VH

// Register offsets on the register port.
`define OFS_TIMER_CONFIG     8'h06
`define OFS_SUBSECOND        8'h07
`define OFS_SECONDS          8'h08
`define OFS_MINUTES          8'h09
`define OFS_HOURS            8'h0A
`define OFS_WEEKDAY          8'h0B
`define OFS_MONTH_DAY        8'h0C
`define OFS_MONTH            8'h0D
`define OFS_YEAR             8'h0E
`define OFS_ALARM1_SECONDS   8'h0F

// Reset values.
`define RST_TIMER_CONFIG     8'h04
`define RST_SECONDS          8'h00
`define RST_MINUTES          8'h00
`define RST_HOURS            8'h00
`define RST_WEEKDAY          3'h1
`define RST_MONTH_DAY        8'h01
`define RST_MONTH            8'h01
`define RST_YEAR             8'h00
`define RST_ALARM1_SECONDS   8'h00

// Implemented bits of each register.
`define MSK_TIMER_CONFIG     8'h1F
`define MSK_SECONDS          8'h7F
`define MSK_MINUTES          8'h7F
`define MSK_HOURS            8'h7F
`define MSK_WEEKDAY          8'h07
`define MSK_MONTH_DAY        8'h3F
`define MSK_MONTH            8'h9F

// Field positions.
`define TMR_ENABLE_BIT       4
`define TMR_HOLD_BIT         3
`define TMR_REPEAT_BIT       2
`define HR_FORMAT_BIT        6
`define HR_PM_BIT            5
`define CENTURY_BIT          7
`define ALM1_MASK_BIT        7

// Timebase: clock rate and the base tick rate, both in Hz.
`define CLK_HZ               50000000
`define BASE_TICK_HZ         1024
`define BASE_TICK_CYCLES     (`CLK_HZ / `BASE_TICK_HZ)

// Calendar limits in BCD.
`define BCD_SEC_MAX          8'h59
`define BCD_YEAR_MAX         8'h99
`define BCD_MONTH_MAX        8'h12

`endif

// file: verilog/base_tick_divider.v
`timescale 1ns/10ps
module base_tick_divider #(
    parameter DIV = 48828
) (
    input  wire        clk,
    input  wire        sys_rst,
    output reg         tick_r
);

    reg  [15:0] cnt_r;

    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_r  <= 16'h0000;
            tick_r <= 1'b0;
        end else if (cnt_r == DIV[15:0] - 16'h0001) begin
            cnt_r  <= 16'h0000;
            tick_r <= 1'b1;
        end else begin
            cnt_r  <= cnt_r + 16'h0001;
            tick_r <= 1'b0;
        end
    end

endmodule

// file: verilog/bcd_wrap_inc.v
`timescale 1ns/10ps
module bcd_wrap_inc (
    input  wire [7:0] val,
    input  wire [7:0] low,
    input  wire [7:0] high,
    output reg  [7:0] nxt,
    output reg        wrap
);

    always @* begin
        wrap = (val >= high);
        if (wrap) begin
            nxt = low;
        end else if (val[3:0] >= 4'h9) begin
            nxt = {val[7:4] + 4'h1, 4'h0};
        end else begin
            nxt = val + 8'h01;
        end
    end

endmodule

// file: verilog/rtc_timekeeper.v
`timescale 1ns/10ps
`include "rtc_defines.vh"
// Functional notes
// - Without repeat, timer halts at zero.
// - With repeat, reload initial count in place of zero.
// - Tick select: 1024, 256, 64, 16 Hz.
// - Sub-second register read-only, resets zero.
// - Seconds BCD, tens 6:4, units 3:0.
// - Minutes BCD, tens 6:4, units 3:0.
// - Hours bit 6 selects 12/24 format.
// - Hours bit 5 is PM or twenties.
// - Hours bit 4 tens, 3:0 units.
// - Date BCD, tens 5:4, resets to 1.
// - Month BCD, tens bit 4, resets 1.
// - Month bit 7 is the century flag.
// - Year BCD, tens 7:4, units 3:0.
// - Alarm seconds mask in bit 7.
// - Alarm seconds BCD compare value.
// - Enable clear holds timer at initial count.
// - Hold freezes count; software clears with enable.
module rtc_timekeeper #(
    parameter BASE_DIV = `BASE_TICK_CYCLES
) (
    input  wire       clk,
    input  wire       sys_rst,
    input  wire [7:0] reg_addr,
    input  wire       reg_wr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_rd,
    output reg  [7:0] reg_rdata_r,
    input  wire [7:0] timer_init,
    output reg  [7:0] timer_count_r,
    output reg        timer_expired_r,
    output reg        alarm1_seconds_hit_r
);

    localparam F_SEC   = 0;
    localparam F_MIN   = 1;
    localparam F_DATE  = 2;
    localparam F_MONTH = 3;
    localparam F_YEAR  = 4;

    reg  [7:0]  timer_cfg_r;
    reg  [9:0]  frac_r;
    reg  [7:0]  sec_r;
    reg  [7:0]  min_r;
    reg  [7:0]  hour_r;
    reg  [2:0]  weekday_r;
    reg  [7:0]  date_r;
    reg  [7:0]  month_r;
    reg  [7:0]  year_r;
    reg  [7:0]  alarm1_sec_r;
    wire        base_tick;
    wire        sec_pulse;
    wire [39:0] cur_vec;
    wire [39:0] low_vec;
    wire [39:0] high_vec;
    wire [39:0] nxt_vec;
    wire [4:0]  wrap_vec;
    reg  [7:0]  hour_nxt;
    reg         midnight;
    reg  [7:0]  rdata_nxt;
    reg         timer_tick;
    wire        wr_sec;
    wire        wr_min;
    wire        wr_hour;
    wire        wr_day;
    wire        wr_date;
    wire        wr_month;
    wire        wr_year;

    function is_leap;
        input [7:0] yr;
        input       cen;
        begin
            if (yr[4])
                is_leap = (yr[3:0] == 4'h2) || (yr[3:0] == 4'h6);
            else
                is_leap = (yr[3:0] == 4'h0) || (yr[3:0] == 4'h4) ||
                          (yr[3:0] == 4'h8);
            if (yr == 8'h00 && cen)
                is_leap = 1'b0;
        end
    endfunction

    function [7:0] month_last_day;
        input [7:0] mon;
        input [7:0] yr;
        input       cen;
        begin
            case (mon)
                8'h02: month_last_day = is_leap(yr, cen) ? 8'h29 : 8'h28;
                8'h04, 8'h06, 8'h09, 8'h11: month_last_day = 8'h30;
                default: month_last_day = 8'h31;
            endcase
        end
    endfunction

    function addr_is;
        input [7:0] a;
        input [7:0] ofs;
        begin
            addr_is = (a == ofs);
        end
    endfunction

    assign wr_sec   = reg_wr && addr_is(reg_addr, `OFS_SECONDS);
    assign wr_min   = reg_wr && addr_is(reg_addr, `OFS_MINUTES);
    assign wr_hour  = reg_wr && addr_is(reg_addr, `OFS_HOURS);
    assign wr_day   = reg_wr && addr_is(reg_addr, `OFS_WEEKDAY);
    assign wr_date  = reg_wr && addr_is(reg_addr, `OFS_MONTH_DAY);
    assign wr_month = reg_wr && addr_is(reg_addr, `OFS_MONTH);
    assign wr_year  = reg_wr && addr_is(reg_addr, `OFS_YEAR);

    base_tick_divider #(
        .DIV (BASE_DIV)
    ) u_div (
        .clk     (clk),
        .sys_rst (sys_rst),
        .tick_r  (base_tick)
    );

    // The fraction counts 1024 Hz ticks; its top seven bits are 1/128 s.
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            frac_r <= 10'h000;
        end else if (wr_sec) begin
            frac_r <= 10'h000;
        end else if (base_tick) begin
            frac_r <= frac_r + 10'h001;
        end
    end

    assign sec_pulse = base_tick && (frac_r == 10'h3FF);

    // Seconds, minutes, date, month and year share one incrementer shape.
    assign cur_vec  = {year_r, {3'h0, month_r[4:0]}, date_r, min_r, sec_r};
    assign low_vec  = {8'h00, 8'h01, 8'h01, 8'h00, 8'h00};
    assign high_vec = {`BCD_YEAR_MAX, `BCD_MONTH_MAX,
                       month_last_day({3'h0, month_r[4:0]}, year_r,
                                      month_r[`CENTURY_BIT]),
                       `BCD_SEC_MAX, `BCD_SEC_MAX};

    genvar gi;
    generate
        for (gi = 0; gi < 5; gi = gi + 1) begin : g_field
            bcd_wrap_inc u_inc (
                .val  (cur_vec[gi*8 +: 8]),
                .low  (low_vec[gi*8 +: 8]),
                .high (high_vec[gi*8 +: 8]),
                .nxt  (nxt_vec[gi*8 +: 8]),
                .wrap (wrap_vec[gi])
            );
        end
    endgenerate

    // Next hour value in either format, with the midnight carry.
    always @* begin
        hour_nxt = hour_r;
        midnight = 1'b0;
        if (hour_r[`HR_FORMAT_BIT]) begin
            if (hour_r[4:0] == 5'h11) begin
                hour_nxt[4:0]        = 5'h12;
                hour_nxt[`HR_PM_BIT] = ~hour_r[`HR_PM_BIT];
                midnight             = hour_r[`HR_PM_BIT];
            end else if (hour_r[4:0] >= 5'h12) begin
                hour_nxt[4:0] = 5'h01;
            end else if (hour_r[3:0] >= 4'h9) begin
                hour_nxt[4:0] = 5'h10;
            end else begin
                hour_nxt[3:0] = hour_r[3:0] + 4'h1;
            end
        end else begin
            if (hour_r[5:0] >= 6'h23) begin
                hour_nxt[5:0] = 6'h00;
                midnight      = 1'b1;
            end else if (hour_r[3:0] >= 4'h9) begin
                hour_nxt[5:0] = {hour_r[5:4] + 2'h1, 4'h0};
            end else begin
                hour_nxt[3:0] = hour_r[3:0] + 4'h1;
            end
        end
    end

    // Calendar registers: a host write to a field takes that field.
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sec_r     <= `RST_SECONDS;
            min_r     <= `RST_MINUTES;
            hour_r    <= `RST_HOURS;
            weekday_r <= `RST_WEEKDAY;
            date_r    <= `RST_MONTH_DAY;
            month_r   <= `RST_MONTH;
            year_r    <= `RST_YEAR;
        end else begin
            if (wr_sec)
                sec_r <= reg_wdata & `MSK_SECONDS;
            else if (sec_pulse)
                sec_r <= nxt_vec[F_SEC*8 +: 8];

            if (wr_min)
                min_r <= reg_wdata & `MSK_MINUTES;
            else if (sec_pulse && wrap_vec[F_SEC])
                min_r <= nxt_vec[F_MIN*8 +: 8];

            if (wr_hour)
                hour_r <= reg_wdata & `MSK_HOURS;
            else if (sec_pulse && wrap_vec[F_SEC] && wrap_vec[F_MIN])
                hour_r <= hour_nxt;

            if (wr_day)
                weekday_r <= reg_wdata[2:0];
            else if (sec_pulse && wrap_vec[F_SEC] && wrap_vec[F_MIN] &&
                     midnight)
                weekday_r <= (weekday_r >= 3'h7) ? 3'h1
                                                 : weekday_r + 3'h1;

            if (wr_date)
                date_r <= reg_wdata & `MSK_MONTH_DAY;
            else if (sec_pulse && wrap_vec[F_SEC] && wrap_vec[F_MIN] &&
                     midnight)
                date_r <= nxt_vec[F_DATE*8 +: 8];

            if (wr_month)
                month_r <= reg_wdata & `MSK_MONTH;
            else if (sec_pulse && wrap_vec[F_SEC] && wrap_vec[F_MIN] &&
                     midnight && wrap_vec[F_DATE])
                month_r <= {month_r[`CENTURY_BIT] ^ wrap_vec[F_MONTH] &
                            wrap_vec[F_YEAR],
                            2'h0, nxt_vec[F_MONTH*8 +: 5]};

            if (wr_year)
                year_r <= reg_wdata;
            else if (sec_pulse && wrap_vec[F_SEC] && wrap_vec[F_MIN] &&
                     midnight && wrap_vec[F_DATE] && wrap_vec[F_MONTH])
                year_r <= nxt_vec[F_YEAR*8 +: 8];
        end
    end

    // Timer configuration and first alarm seconds.
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            timer_cfg_r  <= `RST_TIMER_CONFIG;
            alarm1_sec_r <= `RST_ALARM1_SECONDS;
        end else begin
            if (reg_wr && addr_is(reg_addr, `OFS_TIMER_CONFIG))
                timer_cfg_r <= reg_wdata & `MSK_TIMER_CONFIG;
            if (reg_wr && addr_is(reg_addr, `OFS_ALARM1_SECONDS))
                alarm1_sec_r <= reg_wdata;
        end
    end

    // Slower timer rates are taken from the fraction counter.
    always @* begin
        case (timer_cfg_r[1:0])
            2'h0: timer_tick = base_tick;
            2'h1: timer_tick = base_tick && (frac_r[1:0] == 2'h3);
            2'h2: timer_tick = base_tick && (frac_r[3:0] == 4'hF);
            2'h3: timer_tick = base_tick && (frac_r[5:0] == 6'h3F);
            default: timer_tick = 1'b0;
        endcase
    end

    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            timer_count_r   <= 8'h00;
            timer_expired_r <= 1'b0;
        end else begin
            timer_expired_r <= 1'b0;
            if (!timer_cfg_r[`TMR_ENABLE_BIT]) begin
                timer_count_r <= timer_init;
            end else if (timer_cfg_r[`TMR_HOLD_BIT]) begin
                timer_count_r <= timer_count_r;
            end else if (timer_tick && timer_count_r != 8'h00) begin
                if (timer_count_r == 8'h01) begin
                    timer_expired_r <= 1'b1;
                    if (timer_cfg_r[`TMR_REPEAT_BIT])
                        timer_count_r <= timer_init;
                    else
                        timer_count_r <= 8'h00;
                end else begin
                    timer_count_r <= timer_count_r - 8'h01;
                end
            end
        end
    end

    // A masked seconds field always counts as matching.
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            alarm1_seconds_hit_r <= 1'b0;
        end else begin
            alarm1_seconds_hit_r <= alarm1_sec_r[`ALM1_MASK_BIT] ||
                                    (alarm1_sec_r[6:0] == sec_r[6:0]);
        end
    end

    always @* begin
        case (reg_addr)
            `OFS_TIMER_CONFIG:   rdata_nxt = timer_cfg_r;
            `OFS_SUBSECOND:      rdata_nxt = {1'b0, frac_r[9:3]};
            `OFS_SECONDS:        rdata_nxt = sec_r;
            `OFS_MINUTES:        rdata_nxt = min_r;
            `OFS_HOURS:          rdata_nxt = hour_r;
            `OFS_WEEKDAY:        rdata_nxt = {5'h00, weekday_r};
            `OFS_MONTH_DAY:      rdata_nxt = date_r;
            `OFS_MONTH:          rdata_nxt = month_r;
            `OFS_YEAR:           rdata_nxt = year_r;
            `OFS_ALARM1_SECONDS: rdata_nxt = alarm1_sec_r;
            default:             rdata_nxt = 8'h00;
        endcase
    end

    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst)
            reg_rdata_r <= 8'h00;
        else if (reg_rd)
            reg_rdata_r <= rdata_nxt;
    end

endmodule

// file: test/rtc_timekeeper_properties.sv
`timescale 1ns/10ps
module rtc_timekeeper_properties #(
    parameter BASE_DIV = 4
) (
    input wire       clk,
    input wire       sys_rst,
    input wire [7:0] reg_addr,
    input wire       reg_wr,
    input wire [7:0] reg_wdata,
    input wire       reg_rd,
    input wire [7:0] reg_rdata_r,
    input wire [7:0] timer_init,
    input wire [7:0] timer_count_r,
    input wire       timer_expired_r,
    input wire       alarm1_seconds_hit_r
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Count of the cycle before, so that a single down-step can be seen.
    reg  [7:0] prev_r;
    wire       dec = (timer_count_r + 8'h01) == prev_r;
    always @(posedge clk or posedge sys_rst)
        if (sys_rst)
            prev_r <= 8'h00;
        else
            prev_r <= timer_count_r;
    subsec_top_a: assert property (
        reg_rd && reg_addr == 8'h07 |=> !reg_rdata_r[7])
        else $error("sub-second top bit set");
    year_store_a: assert property (
        reg_wr && reg_addr == 8'h0E ##2 reg_rd && reg_addr == 8'h0E
        |=> reg_rdata_r == $past(reg_wdata, 3))
        else $error("year read differs from write");
    alarm_mask_a: assert property (
        reg_wr && reg_addr == 8'h0F && reg_wdata[7]
        ##1 !(reg_wr && reg_addr == 8'h0F) |-> ##[0:2] alarm1_seconds_hit_r)
        else $error("masked alarm seconds gave no hit");
    expire_pulse_a: assert property (
        timer_expired_r |=> !timer_expired_r)
        else $error("expiry longer than one cycle");
    expire_cause_a: assert property (
        timer_expired_r |-> prev_r == 8'h01)
        else $error("expiry not from a count of one");
    count_step_a: assert property (
        timer_count_r != prev_r |-> dec || timer_count_r == timer_init)
        else $error("count moved neither down nor to initial");
    zero_halt_a: assert property (
        timer_count_r == 8'h00 |=> !dec)
        else $error("count left zero downwards");
    tick_space_a: assert property (
        dec && BASE_DIV >= 4 |=> !dec [*3])
        else $error("ticks closer than the base rate");
    expired_c: cover property (timer_expired_r);
    reload_c: cover property (timer_expired_r && timer_count_r == timer_init);
    hit_c: cover property (alarm1_seconds_hit_r && reg_wr);
endmodule

bind rtc_timekeeper rtc_timekeeper_properties #(
    .BASE_DIV(BASE_DIV)
) rtc_timekeeper_properties_inst (
    .clk(clk),
    .sys_rst(sys_rst),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_wdata(reg_wdata),
    .reg_rd(reg_rd),
    .reg_rdata_r(reg_rdata_r),
    .timer_init(timer_init),
    .timer_count_r(timer_count_r),
    .timer_expired_r(timer_expired_r),
    .alarm1_seconds_hit_r(alarm1_seconds_hit_r)
);

// file: test/host_model.sv
`timescale 1ns/10ps
module host_model (
    input  wire       clk,
    output reg  [7:0] reg_addr,
    output reg        reg_wr,
    output reg  [7:0] reg_wdata,
    output reg        reg_rd,
    input  wire [7:0] reg_rdata_r
);
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
    end
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(posedge clk);
            #1;
            reg_addr = a;
            reg_wdata = d;
            reg_wr = 1'b1;
            @(posedge clk);
            #1;
            reg_wr = 1'b0;
            reg_wdata = ~d;
        end
    endtask
    task rd(input [7:0] a, output [7:0] d);
        begin
            @(posedge clk);
            #1;
            reg_addr = a;
            reg_rd = 1'b1;
            @(posedge clk);
            #1;
            reg_rd = 1'b0;
            d = reg_rdata_r;
        end
    endtask
endmodule

// file: test/tb.sv
`timescale 1ns/10ps
module tb;
    localparam [79:0]  RST = 80'h04_00_00_00_00_01_01_01_00_00;
    localparam [239:0] WR = {120'h085959_07FF00_095959_0A2323_0A7272,
        120'h0BFF07_0C3131_0D9292_0E9999_0FD9D9};
    localparam [479:0] ROLL = {80'h71_07_31_12_99_52_01_01_81_00,
        80'h23_03_28_02_24_00_04_29_02_24, 80'h19_01_30_09_23_20_01_30_09_23,
        80'h23_06_30_09_23_00_07_01_10_23, 80'h23_02_28_82_00_00_03_01_83_00,
        80'h51_05_15_05_50_72_05_15_05_50};
    reg         clk = 1'b0;
    reg         sys_rst = 1'b1;
    reg  [7:0]  timer_init = 8'h00;
    wire [7:0]  reg_addr, reg_wdata, reg_rdata_r, timer_count_r;
    wire        reg_wr, reg_rd, timer_expired_r, alarm1_seconds_hit_r;
    integer     err_count = 0;
    integer     n_compared = 0;
    integer     i, k, n, m;
    reg  [7:0]  v, u, w;
    reg  [23:0] r;
    always #10 clk = ~clk;
    host_model host_model_inst (.clk(clk), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
        .reg_rdata_r(reg_rdata_r));
    rtc_timekeeper #(.BASE_DIV(4)) rtc_timekeeper_inst (.clk(clk),
        .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
        .timer_init(timer_init), .timer_count_r(timer_count_r),
        .timer_expired_r(timer_expired_r),
        .alarm1_seconds_hit_r(alarm1_seconds_hit_r));
    task chk(input string what, input [15:0] got, input [15:0] exp);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                err_count = err_count + 1;
                $display("wrong value %0s expected %h seen %h",
                         what, exp, got);
            end
        end
    endtask
    task rchk(input [7:0] a, input [7:0] exp);
        begin
            host_model_inst.rd(a, v);
            chk($sformatf("reg %h", a), v, exp);
        end
    endtask
    task give_verdict;
        begin
            $display("compared %0d mismatches %0d", n_compared, err_count);
            if (err_count == 0 && n_compared > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    task wait_chg;
        begin
            u = timer_count_r;
            n = 0;
            while (timer_count_r === u && n < 2000) begin
                @(posedge clk);
                #1;
                n = n + 1;
            end
        end
    endtask
    // Counts expiry pulses in n and zero counts in m over 100 cycles.
    task watch;
        begin
            n = 0;
            m = 0;
            repeat (100) begin
                @(posedge clk);
                #1;
                n = n + (timer_expired_r === 1'b1);
                m = m + (timer_count_r === 8'h00);
            end
        end
    endtask
    // Sets the time to one second before a carry and checks the result.
    task roll(input [79:0] c);
        begin
            host_model_inst.wr(8'h09, 8'h59);
            for (k = 0; k < 5; k = k + 1)
                host_model_inst.wr(8'h0A + k[7:0], c[79 - 8 * k -: 8]);
            host_model_inst.wr(8'h08, 8'h59);
            repeat (4200) @(posedge clk);
            rchk(8'h08, 8'h00);
            rchk(8'h09, 8'h00);
            for (k = 0; k < 5; k = k + 1)
                rchk(8'h0A + k[7:0],
                     c[39-8*k -: 8]);
        end
    endtask
    initial begin
        repeat (10) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        for (i = 6; i < 16; i = i + 1)
            rchk(i[7:0],
                 RST[8*(15-i)+:8]);
        rchk(8'h20, 8'h00);
        $display("reset values done");
        for (i = 0; i < 10; i = i + 1) begin
            r = WR[24 * (9 - i) +: 24];
            host_model_inst.wr(r[23:16], r[15:8]);
            rchk(r[23:16],
                 r[7:0]);
        end
        $display("register store done");
        host_model_inst.wr(8'h08, 8'h30);
        host_model_inst.wr(8'h0F, 8'h30);
        repeat (3) @(posedge clk);
        chk("alarm hit", alarm1_seconds_hit_r, 16'h0001);
        host_model_inst.wr(8'h0F, 8'h31);
        repeat (3) @(posedge clk);
        chk("alarm hit", alarm1_seconds_hit_r, 16'h0000);
        host_model_inst.wr(8'h0F, 8'hB1);
        repeat (3) @(posedge clk);
        chk("alarm hit", alarm1_seconds_hit_r, 16'h0001);
        $display("alarm compare done");
        for (i = 0; i < 6; i = i + 1)
            roll(ROLL[80 * (5 - i) +: 80]);
        $display("rollover done");
        timer_init = 8'h03;
        host_model_inst.wr(8'h06, 8'h00);
        chk("timer count", timer_count_r, 16'h0003);
        host_model_inst.wr(8'h06, 8'h10);
        watch;
        chk("expiries", n[15:0], 16'h0001);
        chk("timer count", timer_count_r, 16'h0000);
        timer_init = 8'h02;
        host_model_inst.wr(8'h06, 8'h00);
        host_model_inst.wr(8'h06, 8'h14);
        watch;
        chk("zero counts", m[15:0], 16'h0000);
        chk("reloads", n >= 10, 16'h0001);
        timer_init = 8'hC8;
        for (i = 0; i < 4; i = i + 1) begin
            host_model_inst.wr(8'h06, 8'h00);
            host_model_inst.wr(8'h06, 8'h10 | i[7:0]);
            wait_chg;
            wait_chg;
            chk("tick gap", n[15:0], 16'h0004 << (2 * i));
        end
        host_model_inst.wr(8'h06, 8'h18);
        w = timer_count_r;
        repeat (300) @(posedge clk);
        chk("held count", timer_count_r, w);
        host_model_inst.wr(8'h06, 8'h10);
        wait_chg;
        chk("resumed count", timer_count_r, w - 8'h01);
        host_model_inst.wr(8'h06, 8'h00);
        $display("timer done");
        give_verdict;
    end
    initial begin
        #1000000;
        err_count = err_count + 1;
        $display("watchdog expired");
        give_verdict;
    end
endmodule
